// *** hdl/dds_pkg.sv ***
// package: constants and types for the door driver serial control port
package dds_pkg;
   localparam int WORD_W = 24;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
   localparam int MUX_W = 2;
   localparam int MUX_LSB = 0;
   localparam int NUM_HS = 4;
   typedef logic [WORD_W-1:0] dds_word_t;
   typedef logic [MUX_W-1:0] dds_mux_t;
   typedef enum logic [1:0] {DDS_IDLE, DDS_SHIFT, DDS_DONE} dds_state_t;
endpackage

// *** hdl/dds_edge.sv ***
// edge detector for the sampled serial clock
`timescale 1ns/100ps
module dds_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic sig_in,
   output logic rise,
   output logic fall
);
   logic prev_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= sig_in;
      end
   end
   assign rise = sig_in & ~prev_ff;
   assign fall = ~sig_in & prev_ff;
endmodule

// *** hdl/dds_port.sv ***
// serial control port with bridge steering and current monitor selection
`timescale 1ns/100ps
import dds_pkg::*;

// What this block does
// (RULE_01) serial data output floats while chip select is high.
// (RULE_02) chip select is active low; shifting happens only while it is low.
// (RULE_03) each frame carries exactly one 24-bit control word.
// (RULE_04) bits travel msb first, bit 23 down to bit 0.
// (RULE_05) shift register advances only on serial clock edges.
// (RULE_06) direction input level selects bridge driving direction.
// (RULE_07) pulse input gates the bridge gate drivers.
// (RULE_08) control register mux bits choose mirrored high-side current.
// (RULE_09) diagnosis data is shifted out during a selected transfer.
// (RULE_10) control word applies only when chip select rises after 24 clocks.
module dds_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select_low,
   input wire logic serial_clk,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic bridge_dir_in,
   input wire logic bridge_pulse_in,
   input wire logic [dds_pkg::WORD_W-1:0] diag_in,
   input wire logic [dds_pkg::NUM_HS-1:0] hs_current_in,
   output logic current_mirror_out,
   output logic bridge_fwd,
   output logic bridge_rev,
   output logic [dds_pkg::WORD_W-1:0] ctrl_word
);
   import dds_pkg::*;

   // ==========================================
   // framing
   logic sclk_rise;
   logic sclk_fall;
   logic cs_prev_ff;
   logic [CNT_W-1:0] bit_cnt_ff;
   dds_word_t rx_ff;
   dds_word_t tx_ff;
   dds_word_t ctrl_ff;
   dds_state_t state_ff;
   logic selected;
   logic frame_end;

   dds_edge u_edge (
      .clk(clk),
      .rst(rst),
      .sig_in(serial_clk),
      .rise(sclk_rise),
      .fall(sclk_fall)
   );

   assign selected = ~chip_select_low; // RULE_02
   assign frame_end = chip_select_low & ~cs_prev_ff;

   function automatic dds_mux_t mux_sel(input dds_word_t w);
      mux_sel = w[MUX_LSB +: MUX_W];
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_prev_ff <= 1'b1;
      end else begin
         cs_prev_ff <= chip_select_low;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= DDS_IDLE;
      end else begin
         unique case (state_ff)
            DDS_IDLE: begin
               if (selected) begin
                  state_ff <= DDS_SHIFT;
               end
            end
            DDS_SHIFT: begin
               if (!selected) begin
                  state_ff <= DDS_IDLE;
               end else if (sclk_rise && bit_cnt_ff == FRAME_BITS - 5'h01) begin
                  state_ff <= DDS_DONE; // RULE_03
               end
            end
            DDS_DONE: begin
               if (!selected) begin
                  state_ff <= DDS_IDLE;
               end else if (sclk_rise) begin
                  // a clock past the 24th marks the frame over-length: never applied
                  state_ff <= DDS_SHIFT; // RULE_03
               end
            end
         endcase
      end
   end

   // ==========================================
   // shift registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_ff <= CNT_ZERO;
         rx_ff <= WORD_RST;
      end else if (!selected) begin
         bit_cnt_ff <= CNT_ZERO;
      end else if (sclk_rise) begin // RULE_05
         rx_ff <= {rx_ff[WORD_W-2:0], serial_in}; // RULE_04
         if (bit_cnt_ff != FRAME_BITS) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_ff <= WORD_RST;
      end else if (!selected) begin
         tx_ff <= diag_in;
      end else if (sclk_fall && bit_cnt_ff != CNT_ZERO) begin // RULE_05
         tx_ff <= {tx_ff[WORD_W-2:0], 1'b0}; // RULE_09
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_out <= 1'b0;
         serial_out_oe <= 1'b0;
      end else begin
         serial_out <= tx_ff[WORD_W-1]; // RULE_09
         serial_out_oe <= selected; // RULE_01
      end
   end

   // ==========================================
   // control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= WORD_RST;
      end else if (frame_end && state_ff == DDS_DONE && bit_cnt_ff == FRAME_BITS) begin
         ctrl_ff <= rx_ff; // RULE_10
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_word <= WORD_RST;
         current_mirror_out <= 1'b0;
         bridge_fwd <= 1'b0;
         bridge_rev <= 1'b0;
      end else begin
         ctrl_word <= ctrl_ff;
         current_mirror_out <= hs_current_in[mux_sel(ctrl_ff)]; // RULE_08
         bridge_fwd <= bridge_pulse_in & bridge_dir_in; // RULE_06 RULE_07
         bridge_rev <= bridge_pulse_in & ~bridge_dir_in; // RULE_06 RULE_07
      end
   end

   // ==========================================
   // assertions
   a_float_desel: assert property ( // RULE_01
      @(posedge clk) disable iff (rst) chip_select_low |=> !serial_out_oe)
      else $error("serial output driven while deselected");
   a_drive_sel: assert property ( // RULE_02
      @(posedge clk) disable iff (rst) !chip_select_low |=> serial_out_oe)
      else $error("serial output not driven while selected");
   a_frame_len: assert property ( // RULE_03
      @(posedge clk) disable iff (rst) state_ff == DDS_DONE |-> bit_cnt_ff == FRAME_BITS)
      else $error("frame done without 24 bits");
   a_msb_first: assert property ( // RULE_04
      @(posedge clk) disable iff (rst)
      (selected && sclk_rise) |=> rx_ff[0] == $past(serial_in))
      else $error("bit not shifted in at lsb");
   a_no_edge_hold: assert property ( // RULE_05
      @(posedge clk) disable iff (rst) (!sclk_rise && selected) |=> $stable(rx_ff))
      else $error("shift register moved without clock edge");
   a_bridge_dir: assert property ( // RULE_06
      @(posedge clk) disable iff (rst)
      bridge_pulse_in |=> (bridge_fwd == $past(bridge_dir_in)) && (bridge_rev != bridge_fwd))
      else $error("bridge direction mismatch");
   a_pulse_gate: assert property ( // RULE_07
      @(posedge clk) disable iff (rst) !bridge_pulse_in |=> !bridge_fwd && !bridge_rev)
      else $error("bridge driven without pulse");
   a_mux_pick: assert property ( // RULE_08
      @(posedge clk) disable iff (rst)
      1'b1 |=> current_mirror_out == $past(hs_current_in[ctrl_ff[MUX_LSB +: MUX_W]]))
      else $error("current mirror mux wrong");
   a_diag_load: assert property ( // RULE_09
      @(posedge clk) disable iff (rst) chip_select_low |=> tx_ff == $past(diag_in))
      else $error("diagnosis word not loaded");
   a_apply_end: assert property ( // RULE_10
      @(posedge clk) disable iff (rst) (ctrl_ff != $past(ctrl_ff))
      |-> $past(frame_end && state_ff == DDS_DONE && bit_cnt_ff == FRAME_BITS))
      else $error("control word applied outside frame end");

   // ==========================================
   // counter, state and output checks
   a_first_bit: assert property ( // RULE_09
      @(posedge clk) disable iff (rst)
      $fell(chip_select_low) |=> serial_out == $past(diag_in[WORD_W-1], 2))
      else $error("first diagnosis bit not presented");
   a_shift_out: assert property ( // RULE_09
      @(posedge clk) disable iff (rst) (selected && sclk_fall && bit_cnt_ff != CNT_ZERO)
      |=> tx_ff == {$past(tx_ff[WORD_W-2:0]), 1'b0})
      else $error("diagnosis word not shifted on falling clock");
   a_cnt_clear: assert property ( // RULE_02
      @(posedge clk) disable iff (rst) chip_select_low |=> bit_cnt_ff == CNT_ZERO)
      else $error("bit counter not cleared while deselected");
   a_idle_desel: assert property ( // RULE_02
      @(posedge clk) disable iff (rst) chip_select_low |=> state_ff == DDS_IDLE)
      else $error("frame state not idle while deselected");
   a_desel_hold: assert property ( // RULE_02
      @(posedge clk) disable iff (rst) chip_select_low |=> $stable(rx_ff))
      else $error("shift register moved while deselected");
   a_cnt_step: assert property ( // RULE_03
      @(posedge clk) disable iff (rst) (selected && sclk_rise && bit_cnt_ff != FRAME_BITS)
      |=> bit_cnt_ff == $past(bit_cnt_ff) + 5'h01)
      else $error("bit counter did not step on clock rise");
   a_cnt_cap: assert property ( // RULE_03
      @(posedge clk) disable iff (rst) 1'b1 |-> bit_cnt_ff <= FRAME_BITS)
      else $error("bit counter beyond frame length");
   a_over_refuse: assert property ( // RULE_03
      @(posedge clk) disable iff (rst)
      (state_ff == DDS_DONE && selected && sclk_rise) |=> state_ff == DDS_SHIFT)
      else $error("over-length frame still marked complete");
   a_ctrl_hold: assert property ( // RULE_10
      @(posedge clk) disable iff (rst) !frame_end |=> $stable(ctrl_ff))
      else $error("control register changed inside a frame");
   a_word_out: assert property ( // RULE_10
      @(posedge clk) disable iff (rst) 1'b1 |=> ctrl_word == $past(ctrl_ff))
      else $error("applied control word not presented");
   a_bridge_excl: assert property ( // RULE_06
      @(posedge clk) disable iff (rst) 1'b1 |-> !(bridge_fwd && bridge_rev))
      else $error("both bridge directions driven");
endmodule

// *** verification/dds_host.sv ***
// host-side serial master model
`timescale 1ns/100ps
module dds_host (
   input wire logic clk,
   output logic chip_select_low,
   output logic serial_clk,
   output logic serial_in,
   input wire logic serial_out
);
   initial begin
      chip_select_low = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
   end
   // ==========
   // frame of n bits, msb first; sel low keeps chip select high
   task automatic xfer(input logic [23:0] w, input int n, input bit sel, output logic [23:0] rx);
      rx = 24'h000000;
      @(posedge clk) chip_select_low <= ~sel;
      repeat (2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         serial_in <= w[(47 - i) % 24];
         @(posedge clk) serial_clk <= 1'b1;
         @(posedge clk) rx = {rx[22:0], serial_out};
         @(posedge clk) serial_clk <= 1'b0;
         @(posedge clk);
      end
      @(posedge clk) chip_select_low <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// *** verification/tb_dds_port.sv ***
// testbench for the door driver serial control port
`timescale 1ns/100ps
module tb_dds_port;
   import dds_pkg::*;
   logic clk, rst, chip_select_low, serial_clk, serial_in, serial_out, serial_out_oe;
   logic bridge_dir_in, bridge_pulse_in, current_mirror_out, bridge_fwd, bridge_rev;
   dds_word_t diag_in, ctrl_word, rx;
   logic [NUM_HS-1:0] hs_current_in;
   int n_fail = 0;
   int comparisons = 0;
   dds_port u_dds_port (.clk(clk), .rst(rst), .chip_select_low(chip_select_low),
      .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .bridge_dir_in(bridge_dir_in),
      .bridge_pulse_in(bridge_pulse_in), .diag_in(diag_in), .hs_current_in(hs_current_in),
      .current_mirror_out(current_mirror_out), .bridge_fwd(bridge_fwd),
      .bridge_rev(bridge_rev), .ctrl_word(ctrl_word));
   dds_host u_dds_host (.clk(clk), .chip_select_low(chip_select_low),
      .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out));
   // ==========
   // checks and scenarios
   task automatic chk(input dds_word_t got, input dds_word_t exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic t_frame;
      @(posedge clk) diag_in <= 24'hA5C396;
      repeat (2) @(posedge clk);
      chk(24'(serial_out_oe), 24'h000000);
      u_dds_host.xfer(24'h3C5A02, 24, 1'b1, rx);
      chk(rx, 24'hA5C396);
      chk(ctrl_word, 24'h3C5A02);
      chk(24'(serial_out_oe), 24'h000000);
      $display("frame test done");
   endtask
   task automatic t_refuse;
      u_dds_host.xfer(24'hFFFFFF, 23, 1'b1, rx);
      chk(ctrl_word, 24'h3C5A02);
      u_dds_host.xfer(24'hFFFFFF, 25, 1'b1, rx);
      chk(ctrl_word, 24'h3C5A02);
      u_dds_host.xfer(24'hFFFFFF, 24, 1'b0, rx);
      chk(ctrl_word, 24'h3C5A02);
      $display("refuse test done");
   endtask
   task automatic t_mux;
      for (int i = 0; i < 4; i++) begin
         u_dds_host.xfer({22'h000000, 2'(i)}, 24, 1'b1, rx);
         @(posedge clk) hs_current_in <= 4'h1 << i;
         repeat (3) @(posedge clk);
         chk(24'(current_mirror_out), 24'h000001);
         hs_current_in <= ~(4'h1 << i);
         repeat (3) @(posedge clk);
         chk(24'(current_mirror_out), 24'h000000);
      end
      $display("mux test done");
   endtask
   task automatic t_bridge;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) bridge_dir_in <= k[0];
         bridge_pulse_in <= k[1];
         repeat (3) @(posedge clk);
         chk(24'({bridge_fwd, bridge_rev}), 24'({k[1] & k[0], k[1] & ~k[0]}));
      end
      $display("bridge test done");
   endtask
   task automatic close_out;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========
   // clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      bridge_dir_in = 1'b0;
      bridge_pulse_in = 1'b0;
      diag_in = 24'h000000;
      hs_current_in = 4'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_frame();
      t_refuse();
      t_mux();
      t_bridge();
      close_out();
   end
endmodule
